// ### src/ums_pins.sv
// dual-channel serial and modem pin block with a plain register port
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ums_pins
    import ums_pkg::*;
#(
    parameter int BIT_CYC = BIT_CYC_DEF
) (
    // clock, reset, enable
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       clk_en,
    // register port
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // channel a pins
    output logic            serial_out_chan_a,
    input  wire logic       serial_in_chan_a,
    output logic            request_to_send_n_a,
    input  wire logic       clear_to_send_n_a,
    output logic            terminal_ready_n_a,
    input  wire logic       set_ready_n_a,
    input  wire logic       carrier_detect_n_a,
    input  wire logic       ring_indicator_n_a,
    output logic            user_output_two_n_a,
    output logic            irq_out_a,
    output logic            irq_out_oe_a,
    // channel b pins
    output logic            serial_out_chan_b,
    input  wire logic       serial_in_chan_b,
    output logic            request_to_send_n_b,
    input  wire logic       clear_to_send_n_b,
    output logic            terminal_ready_n_b,
    input  wire logic       set_ready_n_b,
    input  wire logic       carrier_detect_n_b,
    input  wire logic       ring_indicator_n_b,
    output logic            user_output_two_n_b,
    output logic            irq_out_b,
    output logic            irq_out_oe_b,
    output logic            rx_ready_n_b
);

    // counters are CNT_W wide; half a bit must be at least two cycles
    if (BIT_CYC < 4 || BIT_CYC > (1 << CNT_W) - 1) begin
        $error("BIT_CYC out of range");
    end

    localparam logic [CNT_W-1:0] BIT_LAST  = CNT_W'(BIT_CYC - 1);
    localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(BIT_CYC / 2 - 1);
    // infrared pulse is three sixteenths of a bit, never under one cycle
    localparam int               IR_W      = (BIT_CYC * 3 / 16 < 1) ? 1 : BIT_CYC * 3 / 16;
    localparam logic [CNT_W-1:0] IR_EDGE   = CNT_W'(BIT_CYC - 1 - IR_W);
    // a received pulse is stretched to most of a bit so the mid-bit sample sees it
    localparam logic [CNT_W-1:0] IR_HOLD   = CNT_W'(BIT_CYC - 2);

    typedef struct packed {
        ums_chan_t [1:0] ch;
        logic [7:0]      rdata;
    } ums_state_t;

    ums_state_t  q;
    ums_state_t  d;
    ums_pin_in_t pin_in [2];

    assign pin_in[0] = '{serial_in: serial_in_chan_a, cts_n: clear_to_send_n_a,
                         dsr_n: set_ready_n_a, cd_n: carrier_detect_n_a,
                         ri_n: ring_indicator_n_a};
    assign pin_in[1] = '{serial_in: serial_in_chan_b, cts_n: clear_to_send_n_b,
                         dsr_n: set_ready_n_b, cd_n: carrier_detect_n_b,
                         ri_n: ring_indicator_n_b};

    // receive line as the deserialiser sees it, per mode
    function automatic logic rx_level(input ums_chan_t c, input logic pin);
        if (c.modem_control_reg[MCR_IR]) begin
            rx_level = ~(pin | (c.ir_cnt != '0));
        end else begin
            rx_level = pin;
        end
    endfunction

    // transmit pin level for the current bit
    function automatic logic tx_level(input ums_chan_t c);
        logic bit_v;
        bit_v = 1'b1;
        unique case (c.tx_st)
            UMS_TX_IDLE:  bit_v = 1'b1;
            UMS_TX_START: bit_v = 1'b0;
            UMS_TX_DATA:  bit_v = c.tx_shift[0];
            UMS_TX_STOP:  bit_v = 1'b1;
        endcase
        if (c.modem_control_reg[MCR_IR]) begin
            tx_level = ~bit_v && (c.tx_cnt > IR_EDGE);
        end else begin
            tx_level = bit_v;
        end
    endfunction

    function automatic ums_chan_t chan_reset();
        ums_chan_t c;
        c                 = '0;
        c.modem_control_reg             = RST_REG;
        c.enhanced_feature_reg             = RST_REG;
        c.interrupt_enable_reg             = RST_REG;
        c.mask            = RST_REG;
        c.status          = RST_REG;
        c.tx_st           = UMS_TX_IDLE;
        c.rx_st           = UMS_RX_IDLE;
        c.modem_prev      = RST_MODEM;
        c.pins.serial_out = 1'b1;
        c.pins.rts_n      = 1'b1;
        c.pins.dtr_n      = 1'b1;
        c.pins.op2_n      = 1'b1;
        c.pins.rx_ready_n = 1'b1;
        chan_reset        = c;
    endfunction

    always_comb begin
        logic       sel;
        logic [2:0] idx;
        logic [7:0] set_v;
        logic [7:0] clr_v;
        logic [3:0] modem_now;
        logic       line;
        logic       auto_cts;
        logic       auto_rts;
        ums_chan_t  c;
        sel       = 1'b0;
        idx       = reg_addr[2:0];
        set_v     = '0;
        clr_v     = '0;
        modem_now = '0;
        line      = 1'b1;
        auto_cts  = 1'b0;
        auto_rts  = 1'b0;
        c         = '0;
        d         = q;
        if (!rst_n) begin
            // receive pins are not looked at while reset is low
            d.ch[0] = chan_reset();
            d.ch[1] = chan_reset();
            d.rdata = '0;
        end else if (clk_en) begin
            for (int i = 0; i < 2; i++) begin
                c     = q.ch[i];
                sel   = (reg_addr[ADDR_CHAN] == 1'(i));
                set_v = '0;
                clr_v = '0;
                // flow-control enables need the feature bit and the enable bit together
                auto_cts = c.enhanced_feature_reg[EFR_ACTS] & c.interrupt_enable_reg[IER_ACTS];
                auto_rts = c.enhanced_feature_reg[EFR_ARTS] & c.interrupt_enable_reg[IER_ARTS];

                // register writes
                if (reg_wr && sel) begin
                    unique case (idx)
                        OFS_DATA: begin
                            // a write to a full holding register overwrites it
                            c.thr      = reg_wdata;
                            c.thr_full = 1'b1;
                        end
                        OFS_IER:  c.interrupt_enable_reg  = reg_wdata;
                        OFS_MASK: c.mask = reg_wdata;
                        OFS_MCR:  c.modem_control_reg  = reg_wdata;
                        OFS_EFR:  c.enhanced_feature_reg  = reg_wdata;
                        default: ;
                    endcase
                end

                // read side effects; the new set bits below still win
                if (reg_rd && sel) begin
                    if (idx == OFS_DATA) begin
                        c.rx_full = 1'b0;
                    end
                    if (idx == OFS_STATUS) begin
                        clr_v = q.ch[i].status;
                    end
                end

                // transmitter, one bit per BIT_CYC cycles
                unique case (q.ch[i].tx_st)
                    UMS_TX_IDLE: begin
                        // auto clear-to-send only holds off a new character
                        if (q.ch[i].thr_full && !(auto_cts && pin_in[i].cts_n)) begin
                            c.tx_shift      = q.ch[i].thr;
                            // a write in the same cycle refills the holding register
                            c.thr_full      = reg_wr && sel && (idx == OFS_DATA);
                            c.tx_st         = UMS_TX_START;
                            c.tx_cnt        = BIT_LAST;
                            set_v[ST_THRE]  = 1'b1;
                        end
                    end
                    UMS_TX_START: begin
                        if (q.ch[i].tx_cnt == '0) begin
                            c.tx_st  = UMS_TX_DATA;
                            c.tx_bit = '0;
                            c.tx_cnt = BIT_LAST;
                        end else begin
                            c.tx_cnt = q.ch[i].tx_cnt - 1'b1;
                        end
                    end
                    UMS_TX_DATA: begin
                        if (q.ch[i].tx_cnt == '0) begin
                            c.tx_shift = {1'b0, q.ch[i].tx_shift[7:1]};
                            c.tx_bit   = q.ch[i].tx_bit + 1'b1;
                            c.tx_cnt   = BIT_LAST;
                            if (q.ch[i].tx_bit == 3'h7) begin
                                c.tx_st = UMS_TX_STOP;
                            end
                        end else begin
                            c.tx_cnt = q.ch[i].tx_cnt - 1'b1;
                        end
                    end
                    UMS_TX_STOP: begin
                        if (q.ch[i].tx_cnt == '0) begin
                            c.tx_st = UMS_TX_IDLE;
                        end else begin
                            c.tx_cnt = q.ch[i].tx_cnt - 1'b1;
                        end
                    end
                endcase

                // infrared pulse stretcher
                if (pin_in[i].serial_in) begin
                    c.ir_cnt = IR_HOLD;
                end else if (q.ch[i].ir_cnt != '0) begin
                    c.ir_cnt = q.ch[i].ir_cnt - 1'b1;
                end

                // receiver, samples the middle of each bit
                line = rx_level(q.ch[i], pin_in[i].serial_in);
                unique case (q.ch[i].rx_st)
                    UMS_RX_IDLE: begin
                        if (!line) begin
                            c.rx_st  = UMS_RX_START;
                            c.rx_cnt = HALF_LAST;
                        end
                    end
                    UMS_RX_START: begin
                        if (q.ch[i].rx_cnt == '0) begin
                            // a glitch shorter than half a bit is dropped
                            c.rx_st  = line ? UMS_RX_IDLE : UMS_RX_DATA;
                            c.rx_bit = '0;
                            c.rx_cnt = BIT_LAST;
                        end else begin
                            c.rx_cnt = q.ch[i].rx_cnt - 1'b1;
                        end
                    end
                    UMS_RX_DATA: begin
                        if (q.ch[i].rx_cnt == '0) begin
                            c.rx_shift = {line, q.ch[i].rx_shift[7:1]};
                            c.rx_bit   = q.ch[i].rx_bit + 1'b1;
                            c.rx_cnt   = BIT_LAST;
                            if (q.ch[i].rx_bit == 3'h7) begin
                                c.rx_st = UMS_RX_STOP;
                            end
                        end else begin
                            c.rx_cnt = q.ch[i].rx_cnt - 1'b1;
                        end
                    end
                    UMS_RX_STOP: begin
                        if (q.ch[i].rx_cnt == '0) begin
                            c.rx_st = UMS_RX_IDLE;
                            // an unread character is kept, the new one is lost
                            if (c.rx_full) begin
                                set_v[ST_OVR] = 1'b1;
                            end else begin
                                c.receive_holding_reg         = q.ch[i].rx_shift;
                                c.rx_full     = 1'b1;
                                set_v[ST_RX]  = 1'b1;
                            end
                        end else begin
                            c.rx_cnt = q.ch[i].rx_cnt - 1'b1;
                        end
                    end
                endcase

                // modem inputs raise a change flag; clear-to-send also holds off the transmitter under auto flow control
                modem_now    = {pin_in[i].cts_n, pin_in[i].dsr_n,
                                pin_in[i].cd_n, pin_in[i].ri_n};
                c.modem_prev = modem_now;
                if (modem_now != q.ch[i].modem_prev) begin
                    set_v[ST_MODEM] = 1'b1;
                end

                // sticky status: set beats a clear in the same cycle
                c.status = (q.ch[i].status & ~clr_v) | set_v;

                // registered pins
                c.pins.serial_out = tx_level(q.ch[i]);
                c.pins.dtr_n      = ~q.ch[i].modem_control_reg[MCR_DTR];
                if (auto_rts) begin
                    // host must already hold the request bit for this to assert
                    c.pins.rts_n = ~q.ch[i].modem_control_reg[MCR_RTS] | q.ch[i].rx_full;
                end else begin
                    c.pins.rts_n = ~q.ch[i].modem_control_reg[MCR_RTS];
                end
                // interrupt and port 2 share one bit, so port 2 cannot be a free output
                c.pins.irq        = |(q.ch[i].status & q.ch[i].mask);
                c.pins.irq_oe     = q.ch[i].modem_control_reg[MCR_OP2];
                c.pins.op2_n      = ~q.ch[i].modem_control_reg[MCR_OP2];
                c.pins.rx_ready_n = ~q.ch[i].rx_full;
                d.ch[i]           = c;
            end

            // read data, valid in the cycle after the strobe only
            if (reg_rd) begin
                c = q.ch[reg_addr[ADDR_CHAN]];
                unique case (idx)
                    OFS_DATA:   d.rdata = c.receive_holding_reg;
                    OFS_IER:    d.rdata = c.interrupt_enable_reg;
                    OFS_STATUS: d.rdata = c.status;
                    OFS_MASK:   d.rdata = c.mask;
                    OFS_MCR:    d.rdata = c.modem_control_reg;
                    OFS_LINE: begin
                        d.rdata          = '0;
                        d.rdata[LS_RX]   = c.rx_full;
                        d.rdata[LS_THRE] = ~c.thr_full;
                        d.rdata[LS_IDLE] = ~c.thr_full & (c.tx_st == UMS_TX_IDLE);
                    end
                    OFS_MODEM:  d.rdata = {4'h0, c.modem_prev};
                    OFS_EFR:    d.rdata = c.enhanced_feature_reg;
                endcase
            end else begin
                d.rdata = '0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        q <= d;
    end

    // pin outputs
    assign reg_rdata           = q.rdata;
    assign serial_out_chan_a   = q.ch[0].pins.serial_out;
    assign request_to_send_n_a = q.ch[0].pins.rts_n;
    assign terminal_ready_n_a  = q.ch[0].pins.dtr_n;
    assign user_output_two_n_a = q.ch[0].pins.op2_n;
    assign irq_out_a           = q.ch[0].pins.irq;
    assign irq_out_oe_a        = q.ch[0].pins.irq_oe;
    assign serial_out_chan_b   = q.ch[1].pins.serial_out;
    assign request_to_send_n_b = q.ch[1].pins.rts_n;
    assign terminal_ready_n_b  = q.ch[1].pins.dtr_n;
    assign user_output_two_n_b = q.ch[1].pins.op2_n;
    assign irq_out_b           = q.ch[1].pins.irq;
    assign irq_out_oe_b        = q.ch[1].pins.irq_oe;
    assign rx_ready_n_b        = q.ch[1].pins.rx_ready_n;

endmodule
`default_nettype wire

// ### src/ums_pkg.sv
// constants, field layouts and carrier types of the dual-channel serial and modem pin block
package ums_pkg;

    // register index within a channel; address bit 3 selects channel b
    localparam logic [2:0] OFS_DATA   = 3'h0;
    localparam logic [2:0] OFS_IER    = 3'h1;
    localparam logic [2:0] OFS_STATUS = 3'h2;
    localparam logic [2:0] OFS_MASK   = 3'h3;
    localparam logic [2:0] OFS_MCR    = 3'h4;
    localparam logic [2:0] OFS_LINE   = 3'h5;
    localparam logic [2:0] OFS_MODEM  = 3'h6;
    localparam logic [2:0] OFS_EFR    = 3'h7;
    localparam int         ADDR_CHAN  = 3;

    // modem_control_reg fields
    localparam int MCR_DTR  = 0;
    localparam int MCR_RTS  = 1;
    localparam int MCR_OP2  = 3;
    localparam int MCR_IR   = 6;
    // enhanced_feature_reg and interrupt_enable_reg fields
    localparam int EFR_ARTS = 6;
    localparam int EFR_ACTS = 7;
    localparam int IER_ARTS = 6;
    localparam int IER_ACTS = 7;

    // sticky status bits, mask shares the layout
    localparam int ST_RX    = 0;
    localparam int ST_THRE  = 1;
    localparam int ST_OVR   = 2;
    localparam int ST_MODEM = 3;

    // line status bits
    localparam int LS_RX    = 0;
    localparam int LS_THRE  = 5;
    localparam int LS_IDLE  = 6;

    // reset values
    localparam logic [7:0] RST_REG     = 8'h00;
    localparam logic [3:0] RST_MODEM   = 4'hf;

    // timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int RST_MIN_NS    = 40;
    localparam int RST_MIN_CYC   = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BIT_CYC_DEF   = 16;
    localparam int CNT_W         = 8;

    typedef enum logic [3:0] {
        UMS_TX_IDLE  = 4'b0001,
        UMS_TX_START = 4'b0010,
        UMS_TX_DATA  = 4'b0100,
        UMS_TX_STOP  = 4'b1000
    } ums_tx_st_t;

    typedef enum logic [3:0] {
        UMS_RX_IDLE  = 4'b0001,
        UMS_RX_START = 4'b0010,
        UMS_RX_DATA  = 4'b0100,
        UMS_RX_STOP  = 4'b1000
    } ums_rx_st_t;

    // pins entering one channel
    typedef struct packed {
        logic serial_in;
        logic cts_n;
        logic dsr_n;
        logic cd_n;
        logic ri_n;
    } ums_pin_in_t;

    // registered pins leaving one channel
    typedef struct packed {
        logic serial_out;
        logic rts_n;
        logic dtr_n;
        logic op2_n;
        logic irq;
        logic irq_oe;
        logic rx_ready_n;
    } ums_pin_out_t;

    // whole state of one channel
    typedef struct packed {
        logic [7:0]       modem_control_reg;
        logic [7:0]       enhanced_feature_reg;
        logic [7:0]       interrupt_enable_reg;
        logic [7:0]       mask;
        logic [7:0]       status;
        logic [7:0]       thr;
        logic             thr_full;
        logic [7:0]       tx_shift;
        ums_tx_st_t       tx_st;
        logic [2:0]       tx_bit;
        logic [CNT_W-1:0] tx_cnt;
        logic [7:0]       receive_holding_reg;
        logic             rx_full;
        logic [7:0]       rx_shift;
        ums_rx_st_t       rx_st;
        logic [2:0]       rx_bit;
        logic [CNT_W-1:0] rx_cnt;
        logic [CNT_W-1:0] ir_cnt;
        logic [3:0]       modem_prev;
        ums_pin_out_t     pins;
    } ums_chan_t;

endpackage

// ### tb/ums_modem.sv
// far-side serial party: frames bytes onto a receive pin, decodes a transmit pin
`timescale 1ns/1ps
`default_nettype none
module ums_modem #(
    parameter int BIT_CYC = 16
) (
    // clock and serial lines
    input  wire logic       ref_clk,
    input  wire logic       line_in,
    output logic            line_out,
    // decoded bytes
    output logic      [7:0] got_byte,
    output int              got_cnt
);
    // line rests high between frames, like a pulled-up wire
    initial line_out = 1'b1;
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            line_out <= f[i];
            repeat (BIT_CYC) @(posedge ref_clk);
        end
    endtask
    // sample mid-bit, clear of the edges where the pin updates
    initial begin
        got_cnt  = 0;
        got_byte = 8'h00;
        forever begin
            wait (line_in === 1'b1);
            wait (line_in === 1'b0);
            repeat (BIT_CYC + BIT_CYC / 2) @(posedge ref_clk);
            for (int i = 0; i < 8; i++) begin
                got_byte[i] = line_in;
                repeat (BIT_CYC) @(posedge ref_clk);
            end
            got_cnt++;
        end
    end
endmodule
`default_nettype wire

// ### tb/ums_pins_asserts.sv
// concurrent checks on the pins of the serial and modem block
`timescale 1ns/1ps
`default_nettype none
module ums_pins_asserts
    import ums_pkg::*;
#(
    parameter int BIT_CYC = BIT_CYC_DEF
) (
    // clock and register port
    input wire logic       ref_clk,
    input wire logic       rst_n,
    input wire logic       clk_en,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    // pins
    input wire logic       serial_out_chan_a,
    input wire logic       request_to_send_n_a,
    input wire logic       terminal_ready_n_a,
    input wire logic       user_output_two_n_a,
    input wire logic       irq_out_oe_a,
    input wire logic       terminal_ready_n_b,
    input wire logic       user_output_two_n_b,
    input wire logic       irq_out_oe_b,
    input wire logic       rx_ready_n_b
);
    // a held char plus one in flight: idle is only certain after two frames
    localparam int QUIET = 21 * BIT_CYC + 4;
    logic ir_q;
    int   quiet_q;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ir_q    <= 1'b0;
            quiet_q <= 0;
        end else if (clk_en && reg_wr && reg_addr inside {4'h0, 4'h4}) begin
            quiet_q <= 0;
            ir_q    <= (reg_addr == 4'h4) ? reg_wdata[MCR_IR] : ir_q;
        end else if (quiet_q < QUIET) begin
            quiet_q <= quiet_q + 1;
        end
    end

    sequence s_mcr_wr(b);
        clk_en && reg_wr && reg_addr == {b, OFS_MCR};
    endsequence
    sequence s_rd_rx_b;
        clk_en && reg_rd && reg_addr == {1'b1, OFS_DATA};
    endsequence

    a_reset_pins_out: assert property (disable iff (1'b0) !rst_n |=> serial_out_chan_a
        && request_to_send_n_a && user_output_two_n_a && !irq_out_oe_a && rx_ready_n_b)
        else $error("pins not at reset level");
    a_mcr_a_pins: assert property (s_mcr_wr(1'b0) |-> ##2
        terminal_ready_n_a == !$past(reg_wdata[MCR_DTR], 2))
        else $error("terminal ready a does not follow control write");
    a_oe_a_follow: assert property (s_mcr_wr(1'b0) |-> ##2
        irq_out_oe_a == $past(reg_wdata[MCR_OP2], 2)) else $error("irq enable a wrong");
    a_mcr_b_pins: assert property (s_mcr_wr(1'b1) |-> ##2
        terminal_ready_n_b == !$past(reg_wdata[MCR_DTR], 2)
        && irq_out_oe_b == $past(reg_wdata[MCR_OP2], 2)) else $error("channel b pins wrong");
    a_op2_irq_pair: assert property (user_output_two_n_a != irq_out_oe_a
        && user_output_two_n_b != irq_out_oe_b) else $error("port 2 and irq enable disagree");
    a_tx_idle_lvl: assert property (quiet_q >= QUIET |->
        serial_out_chan_a == !ir_q) else $error("transmit idle level wrong");
    a_rx_ready_clr: assert property (s_rd_rx_b |-> ##2 rx_ready_n_b)
        else $error("receiver ready not released after read");
    a_rx_ready_hold: assert property (!rx_ready_n_b && !reg_rd && !$past(reg_rd) |=>
        !rx_ready_n_b) else $error("receiver ready dropped without read");
endmodule

bind ums_pins ums_pins_asserts #(.BIT_CYC(BIT_CYC)) u_chk (
    .ref_clk, .rst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .serial_out_chan_a,
    .request_to_send_n_a, .terminal_ready_n_a, .user_output_two_n_a, .irq_out_oe_a,
    .terminal_ready_n_b, .user_output_two_n_b, .irq_out_oe_b, .rx_ready_n_b
);
`default_nettype wire

// ### tb/ums_pins_bench.sv
// self-checking bench of the serial and modem pin block
`timescale 1ns/1ps
`default_nettype none
module ums_pins_bench
    import ums_pkg::*;
;
    localparam int BC = 16;
    logic       ref_clk, rst_n, clk_en, reg_wr, reg_rd, p;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, got_a, got_b;
    logic       so_a, si_a, rts_a, cts_a, dtr_a, dsr_a, cd_a, ri_a, op2_a, irq_a, oe_a;
    logic       so_b, si_b, rts_b, dtr_b, op2_b, irq_b, oe_b, rdy_b;
    int         cnt_a, cnt_b, k;
    int         n_mismatch = 0;
    int         cmp_count = 0;

    ums_pins #(.BIT_CYC(BC)) uut (
        .ref_clk, .rst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .serial_out_chan_a(so_a), .serial_in_chan_a(si_a), .request_to_send_n_a(rts_a),
        .clear_to_send_n_a(cts_a), .terminal_ready_n_a(dtr_a), .set_ready_n_a(dsr_a),
        .carrier_detect_n_a(cd_a), .ring_indicator_n_a(ri_a), .user_output_two_n_a(op2_a),
        .irq_out_a(irq_a), .irq_out_oe_a(oe_a), .serial_out_chan_b(so_b),
        .serial_in_chan_b(si_b), .request_to_send_n_b(rts_b), .clear_to_send_n_b(1'b1),
        .terminal_ready_n_b(dtr_b), .set_ready_n_b(1'b1), .carrier_detect_n_b(1'b1),
        .ring_indicator_n_b(1'b1), .user_output_two_n_b(op2_b), .irq_out_b(irq_b),
        .irq_out_oe_b(oe_b), .rx_ready_n_b(rdy_b));
    ums_modem #(.BIT_CYC(BC)) mdm_a (.ref_clk, .line_in(so_a), .line_out(si_a),
        .got_byte(got_a), .got_cnt(cnt_a));
    ums_modem #(.BIT_CYC(BC)) mdm_b (.ref_clk, .line_in(so_b), .line_out(si_b),
        .got_byte(got_b), .got_cnt(cnt_b));

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    // the sequence needs about a thousand cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        summarize();
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rdc(input string what, input logic [3:0] a, input logic [7:0] exp);
        reg_wr   <= 1'b0;
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
        check(what, reg_rdata, exp);
    endtask
    task automatic wait_a(input int n);
        for (int i = 0; i < 40 * BC && cnt_a < n; i++) tick(1);
    endtask
    task automatic summarize();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        {rst_n, reg_wr, reg_rd, cts_a} = 4'h0;
        {dsr_a, cd_a, ri_a} = 3'b111;
        clk_en    = 1'b1;
        reg_addr  = 4'h0;
        reg_wdata = 8'h00;
        repeat (6) @(posedge ref_clk);
        check("reset_pins", {so_a, so_b, rts_a, dtr_a, op2_a, oe_a, rdy_b, irq_a}, 8'hfa);
        rst_n <= 1'b1;
        tick(1);
        wr({1'b0, OFS_MCR}, 8'h0b);
        tick(2);
        check("pins_on", {4'h0, dtr_a, rts_a, op2_a, oe_a}, 8'h01);
        wr({1'b0, OFS_MCR}, 8'h00);
        tick(2);
        check("pins_off", {4'h0, dtr_a, rts_a, op2_a, oe_a}, 8'h0e);
        // with the enable low a write must not land
        clk_en <= 1'b0;
        wr({1'b0, OFS_MCR}, 8'h0b);
        tick(2);
        check("frozen", {4'h0, dtr_a, rts_a, op2_a, oe_a}, 8'h0e);
        clk_en <= 1'b1;
        // modem inputs move while characters are in flight
        wr({1'b0, OFS_DATA}, 8'ha5);
        tick(2);
        wr({1'b0, OFS_DATA}, 8'h3c);
        {dsr_a, cd_a, ri_a} <= 3'b010;
        wait_a(1);
        check("tx_first", got_a, 8'ha5);
        wait_a(2);
        check("tx_second", got_a, 8'h3c);
        cts_a <= 1'b1;
        wr({1'b0, OFS_EFR}, 8'h80);
        wr({1'b0, OFS_IER}, 8'h80);
        wr({1'b0, OFS_DATA}, 8'h55);
        tick(3 * BC);
        check("cts_hold", {7'h0, so_a}, 8'h01);
        rdc("modem_in", {1'b0, OFS_MODEM}, 8'h0a);
        cts_a <= 1'b0;
        wait_a(3);
        check("cts_go", got_a, 8'h55);
        wr({1'b0, OFS_MCR}, 8'h40);
        tick(2 * BC);
        check("ir_idle", {7'h0, so_a}, 8'h00);
        wr({1'b0, OFS_DATA}, 8'h00);
        k = 0;
        p = 1'b0;
        for (int i = 0; i < 11 * BC; i++) begin
            tick(1);
            k += (so_a === 1'b1 && p === 1'b0);
            p = so_a;
        end
        check("ir_pulses", k[7:0], 8'h09);
        wr({1'b1, OFS_MCR}, 8'h0a);
        wr({1'b1, OFS_EFR}, 8'h40);
        wr({1'b1, OFS_IER}, 8'h40);
        wr({1'b1, OFS_MASK}, 8'h01);
        tick(1);
        mdm_b.send(8'h96);
        for (int i = 0; i < 4 * BC && rdy_b !== 1'b0; i++) tick(1);
        tick(2);
        check("rx_full", {5'h0, rdy_b, rts_b, irq_b}, 8'h03);
        rdc("line_b", {1'b1, OFS_LINE}, 8'h61);
        rdc("status_b", {1'b1, OFS_STATUS}, 8'h01);
        rdc("rhr_b", {1'b1, OFS_DATA}, 8'h96);
        tick(2);
        check("rx_empty", {5'h0, rdy_b, rts_b, irq_b}, 8'h04);
        summarize();
    end
endmodule
`default_nettype wire
